/* hdl/pdc_map.svh */
// Purpose: constants of the presettable 8-bit down counter
// Assumes: included by its bare name, definitions only
// Notes:   offsets are byte addresses on the plain register port
//
// Notes on behaviour
// - eight-bit count, zero shown on one output
// - all controls and zero output active low
// - state changes on rising count clock edge
// - enabled and no load: count down by one
// - enable high: count holds steady
// - zero output low at zero while enabled
// - sync load takes load value on edge
// - async load forces load value at once; here it is taken at the next mclk edge
// - master clear forces count to 255
// - priority clear, async load, sync load, enable
// - down from zero wraps to 255
// - load_value bit seven is most significant
`ifndef PDC_MAP_SVH
`define PDC_MAP_SVH

// ==========================================================
// register offsets
`define PDC_CTRL_OFS    4'h0
`define PDC_COUNT_OFS   4'h4
`define PDC_STATUS_OFS  4'h8
`define PDC_MASK_OFS    4'hC

// ==========================================================
// field positions
`define PDC_CTRL_TSEL   0
`define PDC_COUNT_ZERO  8
`define PDC_ST_ZERO     0
`define PDC_ST_WRAP     1
`define PDC_ST_LOAD     2
`define PDC_ST_NUM      3

// ==========================================================
// reset and count values
`define PDC_CNT_MAX     8'hFF
`define PDC_CNT_ZERO    8'h00
`define PDC_CNT_ONE     8'h01
`define PDC_CTRL_RST    1'h0
`define PDC_MASK_RST    3'h0

`endif

/* hdl/pdc_pkg.sv */
// Purpose: types shared by the down counter files
// Assumes: nothing
// Notes:   never imported, always scoped
`default_nettype none

package pdc_pkg;

  // ========================================================
  // count word
  typedef logic [7:0] pdc_count_t;

  // ========================================================
  // action chosen on a cycle, lowest priority first
  typedef enum logic [2:0] {
    PDC_ACT_HOLD  = 3'b000,
    PDC_ACT_DOWN  = 3'b001,
    PDC_ACT_SLOAD = 3'b010,
    PDC_ACT_ALOAD = 3'b011,
    PDC_ACT_CLEAR = 3'b100
  } pdc_act_e;

endpackage

`default_nettype wire

/* hdl/pdc_edge_det.sv */
// Purpose: rising edge finder for a sampled level
// Assumes: input already synchronous to mclk
// Notes:   one cycle pulse, in the same cycle the rise is seen
`default_nettype none

module pdc_edge_det (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // level in, pulse out
  input  wire logic level_in,
  output var  logic rise_pulse
);

  logic prev_r;  // level one cycle back

  // ==========================================================
  // history flop; reset high so a level high at release
  // is not mistaken for an edge
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prev_r <= 1'b1;
    end else begin
      prev_r <= level_in;
    end
  end

  // low last cycle, high now
  assign rise_pulse = level_in & ~prev_r;

endmodule

`default_nettype wire

/* hdl/pdc_sticky_bit.sv */
// Purpose: one sticky status bit, write one to clear
// Assumes: set and clear are one cycle strobes or levels
// Notes:   a set in the clearing cycle wins
`default_nettype none

module pdc_sticky_bit #(
  parameter logic RST_VAL = 1'b0  // value after reset
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // event and software clear
  input  wire logic set_in,
  input  wire logic clr_in,
  output var  logic flag_r
);

  // ==========================================================
  // set beats clear so no event is lost
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flag_r <= RST_VAL;
    end else if (set_in) begin
      flag_r <= 1'b1;
    end else if (clr_in) begin
      flag_r <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* hdl/pdc_down_counter8.sv */
// Purpose: presettable 8-bit down counter with register port
// Assumes: all pins synchronous to mclk, one clock domain
// Notes:   count clock is sampled, async controls act at the
//          next mclk edge, zero output is registered
`include "pdc_map.svh"
`default_nettype none

module pdc_down_counter8 #(
  parameter int AW = 4,   // register address width
  parameter int DW = 32   // register data width
) (
  // system clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_n,
  // counter pins
  input  wire logic          count_clock,
  input  wire logic          master_clear_n,
  input  wire logic          async_load_n,
  input  wire logic          sync_load_n,
  input  wire logic          count_enable_n,
  input  wire logic [7:0]    load_value,
  output var  logic          zero_count_n,
  // register port
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic          wr_en,
  input  wire logic          rd_en,
  output var  logic [DW-1:0] rd_data,
  // interrupt
  output var  logic          irq
);

  // ==========================================================
  // internal state
  pdc_pkg::pdc_count_t count_r;    // the count itself
  pdc_pkg::pdc_count_t count_nxt;  // next count
  pdc_pkg::pdc_act_e   act;        // action of this cycle
  logic                tick_sel_r; // 1: count every mclk
  logic                clk_rise;   // count clock rose
  logic                tick;       // counting edge
  logic                zc_nxt;     // next zero output
  logic [2:0]          mask_r;     // interrupt mask
  logic [2:0]          status;     // sticky flags
  logic [2:0]          st_set;     // flag set events
  logic [2:0]          st_clr;     // flag clears
  logic [DW-1:0]       rd_nxt;     // read mux

  // ==========================================================
  // count clock edge finder
  pdc_edge_det u_edge (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .level_in   (count_clock),
    .rise_pulse (clk_rise)
  );

  // the counting edge is the rising count clock, or every
  // mclk when software picks the internal source
  assign tick = tick_sel_r | clk_rise;

  // ==========================================================
  // action decode in fixed priority; low means active
  always_comb begin
    if (!master_clear_n) begin
      act = pdc_pkg::PDC_ACT_CLEAR;
    end else if (!async_load_n) begin
      act = pdc_pkg::PDC_ACT_ALOAD;
    end else if (tick && !sync_load_n) begin
      act = pdc_pkg::PDC_ACT_SLOAD;
    end else if (tick && !count_enable_n) begin
      act = pdc_pkg::PDC_ACT_DOWN;
    end else begin
      act = pdc_pkg::PDC_ACT_HOLD;
    end
  end

  // ==========================================================
  // next count from the action
  always_comb begin
    unique case (act)
      pdc_pkg::PDC_ACT_CLEAR: begin
        count_nxt = `PDC_CNT_MAX;
      end
      pdc_pkg::PDC_ACT_ALOAD: begin
        // bit 7 of load_value is the top bit
        count_nxt = load_value;
      end
      pdc_pkg::PDC_ACT_SLOAD: begin
        count_nxt = load_value;
      end
      pdc_pkg::PDC_ACT_DOWN: begin
        // zero minus one wraps to the top naturally
        count_nxt = count_r - `PDC_CNT_ONE;
      end
      pdc_pkg::PDC_ACT_HOLD: begin
        count_nxt = count_r;
      end
      default: begin
        // unused codes hold, never corrupt the count
        count_nxt = count_r;
      end
    endcase
  end

  // ==========================================================
  // count register; system reset behaves as master clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count_r <= `PDC_CNT_MAX;
    end else begin
      count_r <= count_nxt;
    end
  end

  // ==========================================================
  // zero output, computed from the next count so that it
  // lines up with the count register; held high whenever
  // counting is disabled, giving cascade stages a clean
  // enable chain
  assign zc_nxt = ~((count_nxt == `PDC_CNT_ZERO) & ~count_enable_n);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      zero_count_n <= 1'b1;
    end else begin
      zero_count_n <= zc_nxt;
    end
  end

  // ==========================================================
  // control register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tick_sel_r <= `PDC_CTRL_RST;
    end else if (wr_en && addr == `PDC_CTRL_OFS) begin
      tick_sel_r <= wr_data[`PDC_CTRL_TSEL];
    end
  end

  // ==========================================================
  // mask register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mask_r <= `PDC_MASK_RST;
    end else if (wr_en && addr == `PDC_MASK_OFS) begin
      mask_r <= wr_data[`PDC_ST_NUM-1:0];
    end
  end

  // ==========================================================
  // events: zero reached, wrap past zero, any preset
  assign st_set[`PDC_ST_ZERO] = ~zc_nxt & zero_count_n;
  assign st_set[`PDC_ST_WRAP] = (act == pdc_pkg::PDC_ACT_DOWN)
                              & (count_r == `PDC_CNT_ZERO);
  assign st_set[`PDC_ST_LOAD] = (act == pdc_pkg::PDC_ACT_ALOAD)
                              | (act == pdc_pkg::PDC_ACT_SLOAD);

  // write one to clear
  assign st_clr = (wr_en && addr == `PDC_STATUS_OFS)
                ? wr_data[`PDC_ST_NUM-1:0] : 3'h0;

  // one sticky cell per event
  for (genvar g = 0; g < `PDC_ST_NUM; g++) begin : g_st
    pdc_sticky_bit #(
      .RST_VAL (1'b0)
    ) u_st (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .set_in (st_set[g]),
      .clr_in (st_clr[g]),
      .flag_r (status[g])
    );
  end

  // ==========================================================
  // interrupt level, one cycle behind the flags
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask_r);
    end
  end

  // ==========================================================
  // read mux; unmapped offsets read zero
  always_comb begin
    rd_nxt = '0;
    unique case (addr)
      `PDC_CTRL_OFS: begin
        rd_nxt[`PDC_CTRL_TSEL] = tick_sel_r;
      end
      `PDC_COUNT_OFS: begin
        rd_nxt[7:0]             = count_r;
        rd_nxt[`PDC_COUNT_ZERO] = zero_count_n;
      end
      `PDC_STATUS_OFS: begin
        rd_nxt[`PDC_ST_NUM-1:0] = status;
      end
      `PDC_MASK_OFS: begin
        rd_nxt[`PDC_ST_NUM-1:0] = mask_r;
      end
      default: begin
        rd_nxt = '0;
      end
    endcase
  end

  // read data stand one cycle, only after a read strobe
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= rd_nxt;
    end else begin
      rd_data <= '0;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_clear_max: assert property (
    !master_clear_n |=> count_r == `PDC_CNT_MAX
  ) else $error("clear did not give max count");

  a_clear_over_load: assert property (
    !master_clear_n && !async_load_n && !sync_load_n
      |=> count_r == `PDC_CNT_MAX
  ) else $error("clear lost priority to a load");

  a_async_load: assert property (
    master_clear_n && !async_load_n
      |=> count_r == $past(load_value)
  ) else $error("async load value not taken");

  a_sync_load: assert property (
    master_clear_n && async_load_n && !sync_load_n && tick
      |=> count_r == $past(load_value)
  ) else $error("sync load value not taken");

  a_count_down: assert property (
    master_clear_n && async_load_n && sync_load_n
      && !count_enable_n && tick && count_r != `PDC_CNT_ZERO
      |=> count_r == $past(count_r) - `PDC_CNT_ONE
  ) else $error("count did not step down by one");

  a_wrap_top: assert property (
    master_clear_n && async_load_n && sync_load_n
      && !count_enable_n && tick && count_r == `PDC_CNT_ZERO
      |=> count_r == `PDC_CNT_MAX
  ) else $error("zero did not wrap to max");

  a_hold_off: assert property (
    master_clear_n && async_load_n
      && (count_enable_n || !tick) && (sync_load_n || !tick)
      |=> $stable(count_r)
  ) else $error("count moved while held");

  // the reset edge is a cause too: the first attempt after a
  // release made on the clock edge still sees the preset
  a_edge_only: assert property (
    $changed(count_r)
      |-> $past(tick || !master_clear_n || !async_load_n || !rst_n)
  ) else $error("count changed without an edge");

  a_zero_out: assert property (
    ##1 zero_count_n
      == !(count_r == `PDC_CNT_ZERO && !$past(count_enable_n))
  ) else $error("zero output wrong");

  a_zero_idle: assert property (
    count_enable_n |=> zero_count_n
  ) else $error("zero output low while disabled");

  a_irq_level: assert property (
    |(status & mask_r) |=> irq
  ) else $error("interrupt missing for unmasked flag");

  a_irq_drop: assert property (
    !(|(status & mask_r)) |=> !irq
  ) else $error("interrupt stuck with no unmasked flag");

  a_rd_idle: assert property (
    !rd_en |=> rd_data == '0
  ) else $error("read data shown without a read");

  a_wrap_flag: assert property (
    st_set[`PDC_ST_WRAP] |=> status[`PDC_ST_WRAP]
  ) else $error("wrap event not latched");

  a_load_flag: assert property (
    master_clear_n && !async_load_n |=> status[`PDC_ST_LOAD]
  ) else $error("async load event not latched");

  c_wrap: cover property (
    count_r == `PDC_CNT_ZERO && act == pdc_pkg::PDC_ACT_DOWN
  );
  c_sync_load: cover property (act == pdc_pkg::PDC_ACT_SLOAD);
  c_zero_low: cover property (!zero_count_n);
  c_irq: cover property (irq);
  c_async_load: cover property (act == pdc_pkg::PDC_ACT_ALOAD);

endmodule

`default_nettype wire

/* verif/pdc_ctl_model.sv */
// Purpose: surrounding logic that makes count clock pulses
// Assumes: one pulse per go request, clocked by mclk
// Notes:   pin rests low between pulses, high and low HI cycles each
`default_nettype none

module pdc_ctl_model #(
  parameter int HI = 3  // cycles high, then cycles low
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // request and pulse
  input  wire logic go,
  output var  logic busy,
  output var  logic count_clock
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] left_r;  // cycles left in the pulse

  // ==========================================================
  // pulse maker: low half kept so the next rise is a real edge
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      left_r <= 4'h0;
    end else if (go && left_r == 4'h0) begin
      left_r <= 4'(2 * HI);
    end else if (left_r != 4'h0) begin
      left_r <= left_r - 4'h1;
    end
  end

  // high only in the first half of a pulse, so a stage feeds a stage
  assign count_clock = (left_r > 4'(HI));
  assign busy        = (left_r != 4'h0);
endmodule

`default_nettype wire

/* verif/testbench.sv */
// Purpose: self-checking bench of the 8-bit down counter
// Assumes: partner model makes count clock pulses
// Notes:   rows carry controls, load word and expected {zero,count}
`include "pdc_map.svh"
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  `define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_fail++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, got); end end

  logic        mclk, rst_n, go, busy, count_clock, zero_count_n, wr_en, rd_en, irq;
  logic [3:0]  ctl;      // clear, async load, sync load, enable
  logic [7:0]  load_value;
  logic [3:0]  addr;
  logic [31:0] wr_data, rd_data, d, e;
  int          n_fail, n_checks;
  logic [20:0] rows [11] = '{
    {4'h7, 8'h00, 9'h1FF}, {4'hE, 8'h00, 9'h1FE}, {4'hF, 8'h00, 9'h1FE},
    {4'hD, 8'h01, 9'h101}, {4'hE, 8'h00, 9'h000}, {4'hF, 8'h00, 9'h100},
    {4'hE, 8'h00, 9'h1FF}, {4'h9, 8'hA5, 9'h1A5}, {4'h3, 8'hA5, 9'h1FF},
    {4'hA, 8'h3C, 9'h13C}, {4'hC, 8'h80, 9'h180}};

  pdc_ctl_model #(.HI(3)) model (.mclk(mclk), .rst_n(rst_n), .go(go), .busy(busy),
    .count_clock(count_clock));

  pdc_down_counter8 uut (.mclk(mclk), .rst_n(rst_n), .count_clock(count_clock),
    .master_clear_n(ctl[3]), .async_load_n(ctl[2]), .sync_load_n(ctl[1]),
    .count_enable_n(ctl[0]), .load_value(load_value), .zero_count_n(zero_count_n),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .irq(irq));

  // ==========================================================
  // clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ==========================================================
  // bus tasks: strobe one cycle, read data sampled after the next edge
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    addr    <= a;
    wr_data <= v;
    wr_en   <= 1'b1;
    @(posedge mclk);
    wr_en   <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge mclk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask

  // one count clock pulse, bounded wait for the model to finish
  task automatic pulse;
    int k;
    @(posedge mclk);
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    k = 0;
    do begin
      @(posedge mclk);
      #1 k++;
    end while (busy && k < 20);
    if (busy) n_fail++;
  endtask

  // irq lags its cause by one edge
  task automatic settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // watchdog: the whole run needs well under this
  initial begin
    #100us;
    n_fail++;
    end_sim();
  end

  // ==========================================================
  // main sequence
  initial begin
    {rst_n, go, wr_en, rd_en} = 4'h0;
    ctl = 4'hF;
    load_value = 8'h00;
    addr = 4'h0;
    wr_data = 32'h0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    rd(`PDC_CTRL_OFS, d);   `CHK("ctrl rst", 32'h0, d)
    rd(`PDC_COUNT_OFS, d);  `CHK("count rst", 32'h1FF, d)
    @(posedge mclk);
    #1 `CHK("rd idle", 32'h0, rd_data)
    rd(`PDC_STATUS_OFS, d); `CHK("status rst", 32'h0, d)
    rd(`PDC_MASK_OFS, d);   `CHK("mask rst", 32'h0, d)
    // rows: set pins, one pulse, read the count back
    foreach (rows[i]) begin
      @(posedge mclk);
      ctl        <= rows[i][20:17];
      load_value <= rows[i][16:9];
      pulse();
      rd(`PDC_COUNT_OFS, d);
      `CHK("row count", {23'h0, rows[i][8:0]}, d)
      `CHK("row zero pin", rows[i][8], zero_count_n)
    end
    @(posedge mclk);
    ctl <= 4'hF;
    // sticky events, mask and clear
    rd(`PDC_STATUS_OFS, d); `CHK("status all", 32'h7, d)
    wr(`PDC_MASK_OFS, 32'h1); settle(); `CHK("irq on", 1'b1, irq)
    wr(`PDC_STATUS_OFS, 32'h1); settle(); `CHK("irq off", 1'b0, irq)
    rd(`PDC_STATUS_OFS, d); `CHK("status w1c", 32'h6, d)
    wr(`PDC_MASK_OFS, 32'h7); settle(); `CHK("irq mask", 1'b1, irq)
    wr(`PDC_STATUS_OFS, 32'h7); settle(); `CHK("irq clr", 1'b0, irq)
    rd(`PDC_STATUS_OFS, d); `CHK("status clr", 32'h0, d)
    rd(`PDC_MASK_OFS, d);   `CHK("mask rb", 32'h7, d)
    rd(4'h2, d);            `CHK("unmapped", 32'h0, d)
    wr(`PDC_COUNT_OFS, 32'h0);
    rd(`PDC_COUNT_OFS, d);  `CHK("count ro", 32'h180, d)
    // free counting every mclk: 256 edges apart the count repeats
    wr(`PDC_CTRL_OFS, 32'h1);
    @(posedge mclk);
    ctl <= 4'hE;
    rd(`PDC_COUNT_OFS, d);
    `CHK("free start", 32'h17F, d)
    repeat (254) @(posedge mclk);
    rd(`PDC_COUNT_OFS, e);
    `CHK("free wrap", 32'h17F, e)
    `CHK("wrap period", d[7:0], e[7:0])
    rd(`PDC_STATUS_OFS, d); `CHK("status run", 32'h3, d)
    wr(`PDC_CTRL_OFS, 32'h0);
    // second reset in mid-run
    @(posedge mclk);
    rst_n <= 1'b0;
    ctl   <= 4'hF;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd(`PDC_COUNT_OFS, d);  `CHK("count rerst", 32'h1FF, d)
    end_sim();
  end

  `undef CHK
endmodule

`default_nettype wire
